/* File: hdl/flash_self_program_control.sv */
// Flash self-programming control: control register on APB, armed store and
// load handling, temporary page buffer and section-busy tracking.
// Assumes a flash array that reports flashDone and reads the buffer by index.
`timescale 1ns/1ps
`include "flash_spc_defs.svh"

module flash_self_program_control (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire flash_spc_pkg::cpu_req_t cpuReq,
   input wire logic globalIntEnable,
   input wire logic bootResetFuse,
   input wire logic [7:0] fuseLow,
   input wire logic [7:0] fuseHigh,
   input wire logic [15:0] flashWord,
   input wire logic flashDone,
   input wire logic [4:0] bufIndex,
   output logic [7:0] loadData,
   output logic loadValid,
   output logic cpuHalt,
   output logic readBlock,
   output logic storeReadyIrq,
   output logic [15:0] resetVector,
   output flash_spc_pkg::flash_cmd_t flashCmd,
   output logic [15:0] bufData,
   output logic [5:0] lockBits
);
   flash_spc_pkg::state_t state;
   flash_spc_pkg::cmd_t cmd;
   logic [2:0] winCnt;
   logic irqEnable;
   logic sectionBusy;
   logic ackReg;
   logic [15:0] pageBuf [`WORDS_PER_PAGE];
   logic [`WORDS_PER_PAGE-1:0] written;
   logic [6:0] opPage;
   logic opHalts;
   logic ctrlWrite;
   logic storeHit;
   logic loadHit;
   logic [7:0] ctrlRead;
   flash_spc_pkg::cmd_t next_cmd;

   // Page part of a pointer
   function automatic logic [6:0] pageOf(input logic [15:0] z);
      pageOf = z[`PAGE_MSB:`PAGE_LSB];
   endfunction

   // True when a page lies in the section that can be programmed while the core keeps running
   function automatic logic inConcurrent(input logic [6:0] pg);
      inConcurrent = (pg < `PAGES_CONCURRENT);
   endfunction

   // Decode of the low five control bits
   // code filter
   always_comb begin
      case (pwdata[4:0])
         `CODE_FILL: next_cmd = flash_spc_pkg::CMD_FILL;
         `CODE_ERASE: next_cmd = flash_spc_pkg::CMD_ERASE;
         `CODE_WRITE: next_cmd = flash_spc_pkg::CMD_WRITE;
         `CODE_LOCK: next_cmd = flash_spc_pkg::CMD_LOCK;
         `CODE_REEN: next_cmd = flash_spc_pkg::CMD_REEN;
         default: next_cmd = flash_spc_pkg::CMD_NONE;
      endcase
   end

   // APB: one wait cycle so read data comes from a flop
   // pready lasts one cycle, but a held access completes again every second cycle
   assign pready = ackReg;
   assign pslverr = ackReg && (paddr != `CTRL_OFFSET);
   assign ctrlWrite = psel && penable && ackReg && pwrite && (paddr == `CTRL_OFFSET);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ackReg <= 1'b0;
      end else begin
         ackReg <= psel && penable && !ackReg;
      end
   end

   // Control register image; bit five stays zero
   // reserved bit
   always_comb begin
      ctrlRead = `CTRL_RESET;
      ctrlRead[`BIT_IRQ_EN] = irqEnable;
      ctrlRead[`BIT_BUSY] = sectionBusy;
      ctrlRead[`BIT_REEN] = (cmd == flash_spc_pkg::CMD_REEN);
      ctrlRead[`BIT_LOCK] = (cmd == flash_spc_pkg::CMD_LOCK);
      ctrlRead[`BIT_PGWR] = (cmd == flash_spc_pkg::CMD_WRITE);
      ctrlRead[`BIT_PGER] = (cmd == flash_spc_pkg::CMD_ERASE);
      ctrlRead[`BIT_EN] = (state != flash_spc_pkg::ST_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !ackReg && !pwrite) begin
         prdata <= (paddr == `CTRL_OFFSET) ? {24'h00_0000, ctrlRead} : 32'h0000_0000;
      end
   end

   // Interrupt enable is writable at any time
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irqEnable <= 1'b0;
      end else if (ctrlWrite) begin
         irqEnable <= pwdata[`BIT_IRQ_EN];
      end
   end

   assign storeReadyIrq = irqEnable && globalIntEnable && (state == flash_spc_pkg::ST_IDLE);

   // A store or load only counts while the window is open
   // A late store is dropped, not queued: it must leave flash and buffer alone
   // armed only
   assign storeHit = cpuReq.storeReq && (state == flash_spc_pkg::ST_ARMED);
   assign loadHit = cpuReq.loadReq && (state == flash_spc_pkg::ST_ARMED) &&
                    (cmd == flash_spc_pkg::CMD_LOCK) && (winCnt >= `LOAD_LAST);

   // Sequencer. Control writes during a flash operation only move the interrupt
   // enable, so software cannot cut an erase short.
   // window and auto-clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= flash_spc_pkg::ST_IDLE;
         cmd <= flash_spc_pkg::CMD_NONE;
         winCnt <= 3'h0;
      end else begin
         case (state)
            flash_spc_pkg::ST_IDLE: begin
               if (ctrlWrite && next_cmd != flash_spc_pkg::CMD_NONE) begin
                  state <= flash_spc_pkg::ST_ARMED;
                  cmd <= next_cmd;
                  winCnt <= `STORE_WINDOW;
               end
            end
            flash_spc_pkg::ST_ARMED: begin
               if (storeHit && (cmd == flash_spc_pkg::CMD_ERASE ||
                                cmd == flash_spc_pkg::CMD_WRITE)) begin
                  state <= flash_spc_pkg::ST_BUSY;
               end else if (storeHit || loadHit || winCnt == `WIN_LAST) begin
                  state <= flash_spc_pkg::ST_IDLE;
                  cmd <= flash_spc_pkg::CMD_NONE;
               end else begin
                  winCnt <= winCnt - 3'h1;
               end
            end
            flash_spc_pkg::ST_BUSY: begin
               if (flashDone) begin
                  state <= flash_spc_pkg::ST_IDLE;
                  cmd <= flash_spc_pkg::CMD_NONE;
               end
            end
            default: begin
               state <= flash_spc_pkg::ST_IDLE;
               cmd <= flash_spc_pkg::CMD_NONE;
            end
         endcase
      end
   end

   // Operation start pulses and the latched target page
   // page write start
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flashCmd.eraseStart <= 1'b0;
         flashCmd.writeStart <= 1'b0;
         opPage <= 7'h00;
         opHalts <= 1'b0;
      end else begin
         flashCmd.eraseStart <= storeHit && (cmd == flash_spc_pkg::CMD_ERASE);
         flashCmd.writeStart <= storeHit && (cmd == flash_spc_pkg::CMD_WRITE);
         if (storeHit && (cmd == flash_spc_pkg::CMD_ERASE ||
                          cmd == flash_spc_pkg::CMD_WRITE)) begin
            opPage <= pageOf(cpuReq.pointer);
            opHalts <= !inConcurrent(pageOf(cpuReq.pointer));
         end
      end
   end
   assign flashCmd.page = opPage;

   assign cpuHalt = (state == flash_spc_pkg::ST_BUSY) && opHalts;

   // Section busy: set wins over a clear in the same cycle
   // busy set
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sectionBusy <= 1'b0;
      end else if (storeHit && (cmd == flash_spc_pkg::CMD_ERASE ||
                                cmd == flash_spc_pkg::CMD_WRITE) &&
                   inConcurrent(pageOf(cpuReq.pointer))) begin
         sectionBusy <= 1'b1;
      end else if (storeHit && (cmd == flash_spc_pkg::CMD_REEN ||
                                cmd == flash_spc_pkg::CMD_FILL)) begin
         sectionBusy <= 1'b0;
      end
   end

   assign readBlock = sectionBusy && inConcurrent(pageOf(cpuReq.pointer));

   // Temporary page buffer; a second write to one entry is dropped
   // fill entry
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         written <= '0;
      end else if ((state == flash_spc_pkg::ST_BUSY && cmd == flash_spc_pkg::CMD_WRITE &&
                    flashDone) ||
                   (storeHit && cmd == flash_spc_pkg::CMD_REEN) ||
                   (ctrlWrite && state == flash_spc_pkg::ST_IDLE &&
                    next_cmd == flash_spc_pkg::CMD_REEN)) begin
         written <= '0;
      end else if (storeHit && cmd == flash_spc_pkg::CMD_FILL) begin
         written[cpuReq.pointer[`WORD_MSB:`WORD_LSB]] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (storeHit && cmd == flash_spc_pkg::CMD_FILL &&
          !written[cpuReq.pointer[`WORD_MSB:`WORD_LSB]]) begin
         pageBuf[cpuReq.pointer[`WORD_MSB:`WORD_LSB]] <= cpuReq.dataPair;
      end
   end

   // Cleared entries read as erased flash
   // so a partial fill programs the rest of the page as erased words
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bufData <= `ERASED_WORD;
      end else begin
         bufData <= written[bufIndex] ? pageBuf[bufIndex] : `ERASED_WORD;
      end
   end

   // Boot lock bits can only be programmed, never released
   // lock program
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lockBits <= `LOCK_RESET;
      end else if (storeHit && cmd == flash_spc_pkg::CMD_LOCK) begin
         lockBits[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB] <= lockBits[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB] &
            cpuReq.dataPair[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB];
      end
   end

   // Load answer one cycle after the request
   // zero means programmed
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         loadData <= 8'h00;
         loadValid <= 1'b0;
      end else begin
         loadValid <= cpuReq.loadReq;
         if (loadHit) begin
            case (cpuReq.pointer[1:0])
               `ZSEL_LOCK: loadData <= {`LOCK_PAD, lockBits};
               `ZSEL_FUSE_HIGH: loadData <= fuseHigh;
               default: loadData <= fuseLow;
            endcase
         end else if (cpuReq.loadReq) begin
            loadData <= cpuReq.pointer[0] ? flashWord[15:8] : flashWord[7:0];
         end
      end
   end

   // Vector taken while reset is held; the fuse is static
   // Limitation: a fuse change only shows after the next reset
   // reset vector
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         resetVector <= bootResetFuse ? `APP_RESET_ADDR : `BOOT_RESET_ADDR;
      end
   end

   // Checks run on core_clk and are muted while reset is held, so the first
   // edge after release is the first one judged
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence armWrite;
      ctrlWrite && state == flash_spc_pkg::ST_IDLE && next_cmd != flash_spc_pkg::CMD_NONE;
   endsequence
   sequence quietWindow;
      (!cpuReq.storeReq && !cpuReq.loadReq) [*4];
   endsequence

   a_window_expiry: assert property (armWrite ##1 quietWindow |=>
      state == flash_spc_pkg::ST_IDLE)
      else $error("store window did not close after four cycles");
   a_window_open: assert property (armWrite |=> state == flash_spc_pkg::ST_ARMED [*4]
      or (state == flash_spc_pkg::ST_ARMED ##[0:3] (cpuReq.storeReq || cpuReq.loadReq)))
      else $error("store window closed early");
   a_bad_code: assert property (ctrlWrite && state == flash_spc_pkg::ST_IDLE &&
      next_cmd == flash_spc_pkg::CMD_NONE |=> state == flash_spc_pkg::ST_IDLE)
      else $error("invalid code armed an operation");
   a_enable_held: assert property (state == flash_spc_pkg::ST_BUSY && !flashDone
      |=> ctrlRead[`BIT_EN])
      else $error("store enable dropped during flash operation");
   a_busy_set: assert property (storeHit && cmd == flash_spc_pkg::CMD_ERASE &&
      inConcurrent(pageOf(cpuReq.pointer)) |=> sectionBusy && flashCmd.eraseStart)
      else $error("section busy not set on erase");
   a_halt_op: assert property ((flashCmd.writeStart || flashCmd.eraseStart) && opHalts
      |-> cpuHalt)
      else $error("cpu not halted for halting-section operation");
   a_page_latch: assert property (flashCmd.eraseStart |=> $stable(flashCmd.page)
      || !cpuHalt && state != flash_spc_pkg::ST_BUSY)
      else $error("latched page moved during operation");
   a_irq_level: assert property (storeReadyIrq |-> irqEnable && !ctrlRead[`BIT_EN])
      else $error("ready interrupt while store enabled");
   a_reserved_zero: assert property (!ctrlRead[`BIT_RSVD])
      else $error("reserved bit read as one");
   a_unarmed_store: assert property (cpuReq.storeReq && state == flash_spc_pkg::ST_IDLE
      |=> $stable(written) && $stable(lockBits))
      else $error("unarmed store changed state");
   a_lock_only_down: assert property ((lockBits & ~$past(lockBits)) == 6'h00)
      else $error("lock bit released");

   // Section busy, buffer housekeeping, control writes while busy, start pulse and readback
   a_busy_hold: assert property (sectionBusy && !storeHit |=> sectionBusy)
      else $error("section busy cleared without a store");
   a_buffer_clear: assert property (state == flash_spc_pkg::ST_BUSY && flashDone &&
      cmd == flash_spc_pkg::CMD_WRITE |=> written == '0)
      else $error("buffer not cleared after page write");
   a_arm_while_busy: assert property (ctrlWrite && state == flash_spc_pkg::ST_BUSY &&
      !flashDone |=> state == flash_spc_pkg::ST_BUSY && $stable(cmd))
      else $error("control write disturbed a flash operation");
   a_start_pulse: assert property (flashCmd.eraseStart |=> !flashCmd.eraseStart)
      else $error("erase start longer than one cycle");
   a_lock_readback: assert property (loadHit && cpuReq.pointer[1:0] == `ZSEL_LOCK
      |=> loadValid && loadData == {`LOCK_PAD, $past(lockBits)})
      else $error("lock readback returned a wrong value");
endmodule

/* File: hdl/flash_spc_defs.svh */
// Constants of the flash self-programming control block.
// Assumes inclusion by bare name from the testbench and the design file.
`ifndef FLASH_SPC_DEFS_SVH
`define FLASH_SPC_DEFS_SVH
`define CTRL_OFFSET 12'h000
`define CTRL_RESET 8'h00
`define BIT_IRQ_EN 7
`define BIT_BUSY 6
`define BIT_RSVD 5
`define BIT_REEN 4
`define BIT_LOCK 3
`define BIT_PGWR 2
`define BIT_PGER 1
`define BIT_EN 0
`define CODE_REEN 5'h11
`define CODE_LOCK 5'h09
`define CODE_WRITE 5'h05
`define CODE_ERASE 5'h03
`define CODE_FILL 5'h01
`define STORE_WINDOW 3'h4
`define LOAD_LAST 3'h2
`define WIN_LAST 3'h1
`define WORD_LSB 1
`define WORD_MSB 5
`define PAGE_LSB 6
`define PAGE_MSB 12
`define WORDS_PER_PAGE 32
`define PAGES_CONCURRENT 7'h60
`define APP_RESET_ADDR 16'h0000
`define BOOT_RESET_ADDR 16'h0c00
`define LOCK_RESET 6'h3f
`define ERASED_WORD 16'hffff
`define LOCK_PAD 2'h3
`define BOOT_LOCK_MSB 5
`define BOOT_LOCK_LSB 2
`define ZSEL_LOCK 2'h1
`define ZSEL_FUSE_HIGH 2'h3
`endif

/* File: hdl/flash_spc_pkg.sv */
// Types shared by the flash self-programming control block.
// Assumes the constants header is on the include path.
package flash_spc_pkg;
   // Operation armed by the control register
   typedef enum logic [2:0] {CMD_NONE, CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK,
                             CMD_REEN} cmd_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} state_t;
   // One cycle request from the CPU core
   typedef struct packed {
      logic storeReq;
      logic loadReq;
      logic [15:0] pointer;
      logic [15:0] dataPair;
   } cpu_req_t;
   // Command to the flash array timing logic
   typedef struct packed {
      logic eraseStart;
      logic writeStart;
      logic [6:0] page;
   } flash_cmd_t;
endpackage

/* File: verification/cpu_core_model.sv */
// CPU core model: one-cycle store and load requests to the flash control.
// Assumes its task is entered just after a rising edge of core_clk.
`timescale 1ns/1ps
module cpu_core_model (
   input wire logic core_clk,
   input wire logic cpuHalt,
   output flash_spc_pkg::cpu_req_t cpuReq
);
   initial begin
      cpuReq = '0;
   end
   // One request after d idle edges; a halted core issues nothing
   task automatic issue(input logic st, input int d, input logic [15:0] p,
                        input logic [15:0] v);
      repeat (d) @(posedge core_clk);
      while (cpuHalt === 1'b1) @(posedge core_clk);
      cpuReq <= '{storeReq: st, loadReq: !st, pointer: p, dataPair: v};
      @(posedge core_clk);
      // Released pointer shows the inverse, so a latched page must not follow it
      cpuReq <= '{storeReq: 1'b0, loadReq: 1'b0, pointer: ~p, dataPair: ~v};
   endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the flash self-programming control block.
// Assumes the constants header on the include path and cpu_core_model.
`timescale 1ns/1ps
`include "flash_spc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin nMismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, gie = 0, fuse = 1, flashDone = 0;
   logic [7:0] fuseLow = 0, fuseHigh = 0, loadData, exp8;
   logic [15:0] flashWord = 0, bufData, resetVector, v;
   logic [4:0] bufIndex = '0;
   logic [4:0] bad[5] = '{5'h00, 5'h1f, 5'h13, 5'h07, 5'h02};
   logic loadValid, cpuHalt, readBlock, storeReadyIrq;
   logic [5:0] lockBits, lockM;
   flash_spc_pkg::cpu_req_t cpuReq;
   flash_spc_pkg::flash_cmd_t flashCmd;
   int nMismatch = 0, comparisons = 0, seed = 32'h2256_2481, i, d;
   int bufM[32];
   flash_self_program_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .globalIntEnable(gie),
      .bootResetFuse(fuse), .fuseLow(fuseLow), .fuseHigh(fuseHigh), .flashWord(flashWord),
      .flashDone(flashDone), .bufIndex(bufIndex), .loadData(loadData),
      .loadValid(loadValid), .cpuHalt(cpuHalt), .readBlock(readBlock),
      .storeReadyIrq(storeReadyIrq), .resetVector(resetVector), .flashCmd(flashCmd),
      .bufData(bufData), .lockBits(lockBits));
   cpu_core_model i_cpu (.core_clk(core_clk), .cpuHalt(cpuHalt), .cpuReq(cpuReq));
   always #10 core_clk = ~core_clk;
   // APB master; waits an edge when a transfer was just released
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dt);
      if (psel) @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, dt};
      @(posedge core_clk);
      penable <= 1;
      // Waits as long as the slave needs; only the watchdog ends a hung access
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdc(input logic [7:0] e);
      apb(0, `CTRL_OFFSET, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask
   // Arm a command, then one store or load from the core
   task automatic op(input logic [7:0] c, input logic st, input int dl, input logic [15:0] p);
      apb(1, `CTRL_OFFSET, c);
      v = $random(seed);
      i_cpu.issue(st, dl, p, v);
   endtask
   task automatic done();
      flashDone <= 1;
      @(posedge core_clk);
      flashDone <= 0;
      @(posedge core_clk);
   endtask
   // Buffer entry appears one cycle after its index
   task automatic bufchk();
      for (int k = 0; k < 32; k++) begin
         bufIndex <= k[4:0];
         @(posedge core_clk);
         @(posedge core_clk);
         `CHK(bufData, bufM[k] < 0 ? 16'hffff : bufM[k][15:0])
      end
   endtask
   task automatic reset_dut(input logic f);
      fuse <= f;
      rst_n <= 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1;
      foreach (bufM[k]) bufM[k] = -1;
      lockM = 6'h3f;
   endtask
   task automatic finish_test();
      $display("Mismatches %0d of %0d comparisons", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Whole run is well under a few thousand cycles
   initial begin
      #100_000;
      nMismatch++;
      finish_test();
   end
   initial begin
      fuseLow = $random(seed);
      fuseHigh = $random(seed);
      flashWord = $random(seed);
      reset_dut(1);
      @(posedge core_clk);
      `CHK(resetVector, 16'h0000)
      `CHK({lockBits, storeReadyIrq}, 7'h7e)
      foreach (bad[k]) begin
         apb(1, `CTRL_OFFSET, {3'b011, bad[k]});
         rdc(8'h00);
      end
      apb(1, 12'h004, 8'h01);
      `CHK(err, 1'b1)
      rdc(8'h00);
      gie <= 1;
      apb(1, `CTRL_OFFSET, 8'h80);
      @(posedge core_clk);
      `CHK(storeReadyIrq, 1'b1)
      gie <= 0;
      @(posedge core_clk);
      `CHK(storeReadyIrq, 1'b0)
      gie <= 1;
      // fifth delay (four idle edges) falls outside the window
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         op(8'h01, 1, i % 5, d[15:0]);
         if (i % 5 < 4 && bufM[d[5:1]] < 0) bufM[d[5:1]] = v;
      end
      rdc(8'h00);
      bufchk();
      // erase, then write the same page
      op(8'h83, 1, 0, 16'h0140);
      @(posedge core_clk);
      `CHK({flashCmd.eraseStart, flashCmd.page}, 8'h85)
      `CHK({cpuHalt, storeReadyIrq}, 2'b00)
      apb(1, `CTRL_OFFSET, 8'h91);
      rdc(8'hc3);
      i_cpu.issue(0, 0, 16'h0000, 16'h0000);
      `CHK(readBlock, 1'b1)
      done();
      `CHK(flashCmd.page, 7'h05)
      rdc(8'hc0);
      `CHK(storeReadyIrq, 1'b1)
      op(8'h91, 1, 2, 16'h0000);
      rdc(8'h80);
      i_cpu.issue(0, 0, 16'h0000, 16'h0000);
      `CHK(readBlock, 1'b0)
      op(8'h85, 1, 1, 16'h0155);
      @(posedge core_clk);
      `CHK({flashCmd.writeStart, flashCmd.page}, 8'h85)
      done();
      foreach (bufM[k]) bufM[k] = -1;
      bufchk();
      op(8'h81, 1, 3, 16'h0042);
      bufM[1] = v;
      rdc(8'h80);
      // Store comes after the window, so only the arm write may drop the fill
      op(8'h91, 1, 4, 16'h0000);
      bufM[1] = -1;
      bufchk();
      op(8'h03, 1, 1, 16'h1800);
      @(posedge core_clk);
      `CHK(cpuHalt, 1'b1)
      done();
      `CHK(cpuHalt, 1'b0)
      rdc(8'h00);
      op(8'h09, 1, 3, 16'h0001);
      lockM = lockM & {v[5:2], 2'b11};
      repeat (2) @(posedge core_clk);
      `CHK(lockBits, lockM)
      for (i = 0; i < 3; i++) begin
         op(8'h09, 0, i, 16'(i + i / 2));
         exp8 = i == 0 ? fuseLow : i == 1 ? {2'b11, lockM} : fuseHigh;
         @(posedge core_clk);
         `CHK({loadValid, loadData}, {1'b1, exp8})
      end
      i_cpu.issue(0, 0, 16'h0201, 16'h0000);
      @(posedge core_clk);
      `CHK({loadValid, loadData}, {1'b1, flashWord[15:8]})
      reset_dut(0);
      @(posedge core_clk);
      `CHK(resetVector, `BOOT_RESET_ADDR)
      bufchk();
      finish_test();
   end
endmodule
